// ---- design/tpwm_timer.sv ----
// Six-channel 16-bit timer with unbuffered and buffered PWM
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tpwm_timer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic wait_mode_i,
	input wire logic stop_mode_i,
	input wire logic ch0_pin_i,
	output logic [5:0] ch_out_o,
	output logic [5:0] ch_oe_o,
	output logic irq_o
);
	tpwm_pkg::tpwm_state_s q_ff;
	tpwm_pkg::tpwm_state_s nxt_q;
	logic tick;
	logic ext_edge;
	logic trst;
	logic ovf;
	tpwm_pkg::tpwm_acc_e acc;
	logic [5:0] en;
	logic [5:0] cmp_ev;

	// Byte-lane merge for 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = d[7:0];
		end
		if (be[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// Index of a channel register inside a block of six, or 7 when outside
	function automatic logic [2:0] ch_index(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		if (a >= base && d < 8'(tpwm_pkg::CH_N * 4) && d[1:0] == 2'b00) begin
			return d[4:2];
		end
		return 3'h7;
	endfunction

	// Channel i is disabled and its compare serves the even partner when linked
	function automatic logic linked_odd(input tpwm_pkg::tpwm_state_s s, input int i);
		// Even partner index written without i-1 so channel 0 never indexes below range
		return (i % 2 == 1) && s.scr[(i / 2) * 2][tpwm_pkg::CS_BUF];
	endfunction

	tpwm_prescaler #(
		.DIV_W(6)
	) u_pre (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(trst),
		.run_i(!q_ff.stop && !stop_mode_i),
		.sel_i(q_ff.ps),
		.ext_tick_i(ext_edge),
		.tick_o(tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode; registers closed in wait and stop
	always_comb begin
		acc = tpwm_pkg::ACC_NONE;
		if (cyc_i && stb_i && !q_ff.ack && !wait_mode_i && !stop_mode_i) begin
			acc = we_i ? tpwm_pkg::ACC_WRITE : tpwm_pkg::ACC_READ;
		end
		trst = acc == tpwm_pkg::ACC_WRITE && adr_i == tpwm_pkg::OFS_SC && sel_i[0]
			&& dat_i[tpwm_pkg::SC_TRST];
	end

	// Rising edge of the settled level from the second and third sync stages only
	assign ext_edge = (q_ff.sync[1] == q_ff.sync[2]) && q_ff.sync[2] && !q_ff.stable;
	// Overflow at modulo match
	assign ovf = tick && (q_ff.cnt == q_ff.modv);

	always_comb begin
		logic [2:0] ci;
		logic [2:0] cc;
		logic [15:0] val;
		logic bufd;
		ci = ch_index(adr_i, tpwm_pkg::OFS_CSC);
		cc = ch_index(adr_i, tpwm_pkg::OFS_CMP);
		val = '0;
		bufd = 1'b0;
		nxt_q = q_ff;
		nxt_q.sync = {q_ff.sync[1:0], ch0_pin_i};
		if (q_ff.sync[1] == q_ff.sync[2]) begin
			nxt_q.stable = q_ff.sync[2];
		end
		nxt_q.ack = cyc_i && stb_i && !q_ff.ack;
		nxt_q.dat = '0;
		en = '0;
		cmp_ev = '0;
		// Register reads
		if (acc == tpwm_pkg::ACC_READ) begin
			if (adr_i == tpwm_pkg::OFS_SC) begin
				nxt_q.dat[7:0] = {q_ff.overflow_flag, q_ff.overflow_irq_enable, q_ff.stop, 1'b0, 1'b0, q_ff.ps};
				nxt_q.arm_tof = q_ff.overflow_flag;
			end else if (adr_i == tpwm_pkg::OFS_CNT) begin
				nxt_q.dat[15:0] = q_ff.cnt;
			end else if (adr_i == tpwm_pkg::OFS_MOD) begin
				nxt_q.dat[15:0] = q_ff.modv;
			end else if (ci != 3'h7) begin
				nxt_q.dat[7:0] = q_ff.scr[ci];
				nxt_q.arm_ch[ci] = q_ff.scr[ci][tpwm_pkg::CS_FLAG];
			end else if (cc != 3'h7) begin
				nxt_q.dat[15:0] = q_ff.cmp[cc];
			end
		end
		// Register writes; flags clear only after an armed read
		if (acc == tpwm_pkg::ACC_WRITE) begin
			if (adr_i == tpwm_pkg::OFS_SC && sel_i[0]) begin
				nxt_q.overflow_irq_enable = dat_i[tpwm_pkg::SC_OVERFLOW_IRQ_ENABLE];
				nxt_q.stop = dat_i[tpwm_pkg::SC_STOP];
				nxt_q.ps = dat_i[2:0];
				if (!dat_i[tpwm_pkg::SC_TOF] && q_ff.arm_tof) begin
					nxt_q.overflow_flag = 1'b0;
					nxt_q.arm_tof = 1'b0;
				end
			end else if (adr_i == tpwm_pkg::OFS_MOD) begin
				nxt_q.modv = merge16(q_ff.modv, dat_i, sel_i);
			end else if (ci != 3'h7 && sel_i[0]) begin
				nxt_q.scr[ci][6:0] = dat_i[6:0] & tpwm_pkg::CSC_WMASK[6:0];
				if (ci[0]) begin
					nxt_q.scr[ci][tpwm_pkg::CS_BUF] = 1'b0;
				end
				if (!dat_i[tpwm_pkg::CS_FLAG] && q_ff.arm_ch[ci]) begin
					nxt_q.scr[ci][tpwm_pkg::CS_FLAG] = 1'b0;
					nxt_q.arm_ch[ci] = 1'b0;
				end
			end else if (cc != 3'h7) begin
				// Plain overwrite of the compare value
				nxt_q.cmp[cc] = merge16(q_ff.cmp[cc], dat_i, sel_i);
				nxt_q.last[cc[2:1]] = cc[0];
			end
		end
		// Counter run; counter reset clears only counter and prescaler
		if (trst) begin
			nxt_q.cnt = '0;
		end else if (tick) begin
			nxt_q.cnt = ovf ? '0 : q_ff.cnt + 1'b1;
		end
		if (ovf) begin
			nxt_q.overflow_flag = 1'b1;
			nxt_q.arm_tof = 1'b0;
		end
		// Channel outputs
		for (int i = 0; i < tpwm_pkg::CH_N; i++) begin
			// Buffered select wins over unbuffered select
			bufd = (i % 2 == 0) && q_ff.scr[i][tpwm_pkg::CS_BUF];
			en[i] = !linked_odd(q_ff, i) && (bufd || q_ff.scr[i][tpwm_pkg::CS_UNB]);
			val = q_ff.cmp[i];
			if (bufd && q_ff.act[i/2]) begin
				val = q_ff.cmp[i | 1];
			end
			cmp_ev[i] = en[i] && tick && (q_ff.cnt == val);
			if (en[i] && ovf && q_ff.scr[i][tpwm_pkg::CS_TOV]) begin
				nxt_q.pin[i] = !q_ff.pin[i];
			end
			if (cmp_ev[i]) begin
				case (q_ff.scr[i][tpwm_pkg::CS_ELSB:tpwm_pkg::CS_ELSA])
					tpwm_pkg::ELS_TOG: nxt_q.pin[i] = !q_ff.pin[i];
					tpwm_pkg::ELS_CLR: nxt_q.pin[i] = 1'b0;
					tpwm_pkg::ELS_SET: nxt_q.pin[i] = 1'b1;
					default: nxt_q.pin[i] = q_ff.pin[i];
				endcase
				nxt_q.scr[i][tpwm_pkg::CS_FLAG] = 1'b1;
				nxt_q.arm_ch[i] = 1'b0;
			end
			// Constant pulse level at full duty
			if (en[i] && q_ff.scr[i][tpwm_pkg::CS_MAX] && q_ff.scr[i][tpwm_pkg::CS_TOV]) begin
				nxt_q.pin[i] = !q_ff.scr[i][tpwm_pkg::CS_ELSA];
			end
		end
		// Pair register swap at each overflow
		for (int p = 0; p < tpwm_pkg::CH_N / 2; p++) begin
			if (!q_ff.scr[2*p][tpwm_pkg::CS_BUF]) begin
				nxt_q.act[p] = 1'b0;
				nxt_q.last[p] = 1'b0;
			end else if (ovf) begin
				nxt_q.act[p] = nxt_q.last[p];
			end
		end
		// Everything except ack holds while stopped; ack clears
		if (stop_mode_i) begin
			nxt_q = q_ff;
			nxt_q.ack = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_ff <= '0;
			q_ff.modv <= tpwm_pkg::MOD_RST;
			q_ff.stop <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs; pin released when channel idle or odd half of a buffered pair
	always_comb begin
		for (int i = 0; i < tpwm_pkg::CH_N; i++) begin
			ch_oe_o[i] = en[i] && (q_ff.scr[i][tpwm_pkg::CS_ELSB:tpwm_pkg::CS_ELSA] != 2'b00);
		end
	end
	assign ch_out_o = q_ff.pin;
	assign dat_o = q_ff.dat;
	assign ack_o = q_ff.ack;
	// Request also serves as wake-up in wait mode
	always_comb begin
		irq_o = q_ff.overflow_flag && q_ff.overflow_irq_enable;
		for (int i = 0; i < tpwm_pkg::CH_N; i++) begin
			irq_o = irq_o || (q_ff.scr[i][tpwm_pkg::CS_FLAG] && q_ff.scr[i][tpwm_pkg::CS_IE]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_ovf_flag;
		ovf && !stop_mode_i |=> q_ff.overflow_flag;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

	property p_wrap;
		ovf && !stop_mode_i && !trst |=> q_ff.cnt == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not restart from zero");

	property p_irq_gate;
		!q_ff.overflow_irq_enable && q_ff.scr == '0 |-> !irq_o;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without enable");

	property p_trst;
		trst && !stop_mode_i |=> q_ff.cnt == 16'h0000 && q_ff.modv == $past(q_ff.modv);
	endproperty
	a_trst: assert property (p_trst) else $error("counter reset misbehaved");

	property p_stop_hold;
		stop_mode_i [*2] |-> $stable(q_ff.cnt) && $stable(q_ff.pin) && !ack_o;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("state moved in stop mode");

	property p_full_duty;
		en[4] && q_ff.scr[4][tpwm_pkg::CS_MAX] && q_ff.scr[4][tpwm_pkg::CS_TOV] && !stop_mode_i
			|=> ch_out_o[4] == !$past(q_ff.scr[4][tpwm_pkg::CS_ELSA]);
	endproperty
	a_full_duty: assert property (p_full_duty) else $error("full duty not held");

	property p_odd_release;
		q_ff.scr[4][tpwm_pkg::CS_BUF] |-> !ch_oe_o[5];
	endproperty
	a_odd_release: assert property (p_odd_release) else $error("odd pin not released");

	property p_swap;
		ovf && q_ff.scr[4][tpwm_pkg::CS_BUF] && acc == tpwm_pkg::ACC_NONE && !stop_mode_i
			|=> q_ff.act[2] == $past(q_ff.last[2]);
	endproperty
	a_swap: assert property (p_swap) else $error("buffered pair did not swap");

	property p_count;
		tick && !ovf && !trst |=> q_ff.cnt == $past(q_ff.cnt) + 16'h0001;
	endproperty
	a_count: assert property (p_count) else $error("counter did not advance");

	property p_cmp_flag;
		cmp_ev[4] |=> q_ff.scr[4][tpwm_pkg::CS_FLAG];
	endproperty
	a_cmp_flag: assert property (p_cmp_flag) else $error("channel flag not set");

	// Without overflow toggle a clear-on-compare pin never leaves low
	property p_zero_duty;
		en[3] && !q_ff.scr[3][tpwm_pkg::CS_TOV] && !q_ff.pin[3]
			&& q_ff.scr[3][tpwm_pkg::CS_ELSB:tpwm_pkg::CS_ELSA] == tpwm_pkg::ELS_CLR
			|=> !ch_out_o[3];
	endproperty
	a_zero_duty: assert property (p_zero_duty) else $error("zero duty broken");

	property p_ovf_toggle;
		en[2] && ovf && q_ff.scr[2][tpwm_pkg::CS_TOV]
			&& !q_ff.scr[2][tpwm_pkg::CS_MAX] && !cmp_ev[2]
			|=> ch_out_o[2] != $past(q_ff.pin[2]);
	endproperty
	a_ovf_toggle: assert property (p_ovf_toggle) else $error("no toggle at overflow");

	property p_clr_on_cmp;
		cmp_ev[0] && !q_ff.scr[0][tpwm_pkg::CS_MAX]
			&& q_ff.scr[0][tpwm_pkg::CS_ELSB:tpwm_pkg::CS_ELSA] == tpwm_pkg::ELS_CLR
			|=> !ch_out_o[0];
	endproperty
	a_clr_on_cmp: assert property (p_clr_on_cmp) else $error("pin not cleared");

	property p_wait_closed;
		wait_mode_i && !stop_mode_i && cyc_i && stb_i && !ack_o
			|=> ack_o && dat_o == 32'h0000_0000 && $stable(q_ff.modv);
	endproperty
	a_wait_closed: assert property (p_wait_closed) else $error("register open in wait");
endmodule
`default_nettype wire

// ---- design/tpwm_pkg.sv ----
// Package of constants and types for the six-channel timer PWM block
package tpwm_pkg;
	localparam int CH_N = 6;
	localparam int CW = 16;
	localparam logic [7:0] OFS_SC = 8'h00;
	localparam logic [7:0] OFS_CNT = 8'h04;
	localparam logic [7:0] OFS_MOD = 8'h08;
	localparam logic [7:0] OFS_CSC = 8'h0C;
	localparam logic [7:0] OFS_CMP = 8'h24;
	localparam logic [7:0] OFS_STEP = 8'h04;
	localparam logic [15:0] MOD_RST = 16'hFFFF;
	// Timer status/control bit positions
	localparam int SC_TOF = 7;
	localparam int SC_OVERFLOW_IRQ_ENABLE = 6;
	localparam int SC_STOP = 5;
	localparam int SC_TRST = 4;
	// Channel status/control bit positions
	localparam int CS_FLAG = 7;
	localparam int CS_IE = 6;
	localparam int CS_BUF = 5;
	localparam int CS_UNB = 4;
	localparam int CS_ELSB = 3;
	localparam int CS_ELSA = 2;
	localparam int CS_TOV = 1;
	localparam int CS_MAX = 0;
	localparam logic [2:0] PS_EXT = 3'h7;
	localparam logic [1:0] ELS_TOG = 2'h1;
	localparam logic [1:0] ELS_CLR = 2'h2;
	localparam logic [1:0] ELS_SET = 2'h3;
	localparam logic [7:0] CSC_WMASK = 8'h7F;

	typedef enum logic [1:0] {
		ACC_NONE = 2'b00,
		ACC_READ = 2'b01,
		ACC_WRITE = 2'b10
	} tpwm_acc_e;

	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] modv;
		logic [5:0][7:0] scr;
		logic [5:0][15:0] cmp;
		logic [5:0] pin;
		logic [2:0] act;
		logic [2:0] last;
		logic arm_tof;
		logic [5:0] arm_ch;
		logic [2:0] sync;
		logic stable;
		logic ack;
		logic [31:0] dat;
		logic overflow_flag;
		logic overflow_irq_enable;
		logic stop;
		logic [2:0] ps;
	} tpwm_state_s;
endpackage

// ---- design/tpwm_prescaler.sv ----
// Prescaler that makes the timer clock tick
`timescale 1ns/1ps
`default_nettype none
module tpwm_prescaler #(
	parameter int DIV_W = 6
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic run_i,
	input wire logic [2:0] sel_i,
	input wire logic ext_tick_i,
	output logic tick_o
);
	logic [DIV_W-1:0] div_ff;
	logic [DIV_W-1:0] nxt_div;
	logic [DIV_W-1:0] mask;

	always_comb begin
		mask = DIV_W'((1 << sel_i) - 1);
		nxt_div = div_ff;
		if (clear_i) begin
			nxt_div = '0;
		end else if (run_i) begin
			nxt_div = div_ff + 1'b1;
		end
	end

	// Divide by 1..64, or the external pin edge
	always_comb begin
		if (sel_i == tpwm_pkg::PS_EXT) begin
			tick_o = run_i & ext_tick_i;
		end else begin
			tick_o = run_i & ((div_ff & mask) == mask);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_ff <= '0;
		end else begin
			div_ff <= nxt_div;
		end
	end
endmodule
`default_nettype wire

// ---- tb/tpwm_pin_model.sv ----
// Pin-side model: external clock source and pulse counter
`timescale 1ns/1ps
`default_nettype none
module tpwm_pin_model (
	input wire logic clk_i,
	input wire logic [5:0] ch_out_i,
	input wire logic [5:0] ch_oe_i,
	output logic ext_clk_o
);
	logic [2:0] div_ff = 3'h0;
	always @(posedge clk_i) begin
		div_ff <= div_ff + 3'h1;
	end
	// Free-running source, one rising edge per eight bus cycles
	assign ext_clk_o = div_ff[2];
	////////////////////////////////////////
	// Released pin reads low, pull-down assumed
	task automatic measure(input int ch, input int len, output int highs);
		highs = 0;
		repeat (len) begin
			@(posedge clk_i);
			if (ch_oe_i[ch] === 1'b1 && ch_out_i[ch] === 1'b1) highs++;
		end
	endtask
endmodule
`default_nettype wire

// ---- tb/test_timer_pwm_channels.sv ----
// Self-checking bench for the timer PWM block
`timescale 1ns/1ps
`default_nettype none
module test_timer_pwm_channels;
	typedef struct {int ch; logic [2:0] ps; logic [7:0] csc; logic [15:0] cmp; int hi;} tpwm_row_s;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wait_m = 1'b0, stop_m = 1'b0, lv;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000, dat_o;
	logic ack_o, irq_o, ext_clk;
	logic [5:0] ch_out, ch_oe;
	int n_errors = 0, check_count = 0, h;
	// Period is ten ticks; window spans whole periods at every rate
	tpwm_row_s rows [7] = '{
		'{0, 3'h0, 8'h1A, 16'h0003, 96},
		'{1, 3'h0, 8'h1E, 16'h0003, 144},
		'{2, 3'h1, 8'h1A, 16'h0003, 96},
		'{3, 3'h0, 8'h18, 16'h0003, 0},
		'{4, 3'h0, 8'h1B, 16'h0003, 240},
		'{5, 3'h2, 8'h1A, 16'h0000, 24},
		'{2, 3'h7, 8'h1A, 16'h0003, 96}};
	always #2 clk_i = ~clk_i;
	tpwm_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
		.wait_mode_i(wait_m), .stop_mode_i(stop_m), .ch0_pin_i(ext_clk),
		.ch_out_o(ch_out), .ch_oe_o(ch_oe), .irq_o(irq_o));
	tpwm_pin_model u_pin (.clk_i(clk_i), .ch_out_i(ch_out), .ch_oe_i(ch_oe), .ext_clk_o(ext_clk));
	////////////////////////////////////////
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		wdat <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack_o !== 1'b1 && t < 100);
		if (t >= 100) n_errors++;
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		chk(nm, q, exp);
	endtask
	task automatic meas(input int ch, input int exp);
		u_pin.measure(ch, 240, h);
		chk("high cycles", 32'(h), 32'(exp));
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		#200000;
		n_errors++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			wr(8'h00, 32'(8'h30 | rows[i].ps)); // Stop and clear first
			wr(tpwm_pkg::OFS_MOD, 32'h0000_0009);
			wr(8'(tpwm_pkg::OFS_CMP + 4 * rows[i].ch), 32'(rows[i].cmp));
			wr(8'(tpwm_pkg::OFS_CSC + 4 * rows[i].ch), 32'(rows[i].csc));
			wr(8'h00, 32'(rows[i].ps));
			repeat (300) @(posedge clk_i);
			meas(rows[i].ch, rows[i].hi);
			chk("enable", 32'(ch_oe[rows[i].ch]), 32'h0000_0001);
			// Stop first so a fresh compare cannot undo the armed clear
			wr(8'h00, 32'h0000_0020);
			rdc("channel flag", 8'(tpwm_pkg::OFS_CSC + 4 * rows[i].ch),
				32'(rows[i].csc | 8'h80));
			wr(8'(tpwm_pkg::OFS_CSC + 4 * rows[i].ch), 32'h0000_0000);
		end
		// Unbuffered width changes inside the matching handlers
		wr(8'h00, 32'h0000_0030);
		wr(tpwm_pkg::OFS_CMP, 32'h0000_0003);
		wr(tpwm_pkg::OFS_CSC, 32'h0000_005A);
		wr(8'h00, 32'h0000_0000);
		for (int k = 0; k < 100 && irq_o !== 1'b1; k++) @(posedge clk_i);
		wr(tpwm_pkg::OFS_CMP, 32'h0000_0001); // Shorter, in compare handler
		repeat (40) @(posedge clk_i);
		meas(0, 48);
		wr(tpwm_pkg::OFS_CSC, 32'h0000_001A);
		wr(8'h00, 32'h0000_0020);
		rdc("status", 8'h00, 32'h0000_00A0);
		wr(8'h00, 32'h0000_0040);
		for (int k = 0; k < 100 && irq_o !== 1'b1; k++) @(posedge clk_i);
		wr(tpwm_pkg::OFS_CMP, 32'h0000_0006); // Longer, in overflow handler
		repeat (40) @(posedge clk_i);
		meas(0, 168);
		wr(tpwm_pkg::OFS_CSC, 32'h0000_0000);
		// Flags: stop first so no fresh overflow races the clear
		wr(8'h00, 32'h0000_0030);
		wr(8'h30, 32'h0000_0003);
		wr(8'h18, 32'h0000_005A);
		wr(8'h00, 32'h0000_0040);
		repeat (30) @(posedge clk_i);
		wr(8'h00, 32'h0000_0060);
		rdc("status", 8'h00, 32'h0000_00E0);
		rdc("ch3 status", 8'h18, 32'h0000_00DA);
		wr(8'h18, 32'h0000_001A);
		chk("irq", 32'(irq_o), 32'h0000_0001);
		wr(8'h00, 32'h0000_00A0);
		chk("irq", 32'(irq_o), 32'h0000_0000);
		wr(8'h00, 32'h0000_0020);
		rdc("status", 8'h00, 32'h0000_0020);
		wr(8'h00, 32'h0000_0030);
		rdc("counter", tpwm_pkg::OFS_CNT, 32'h0000_0000);
		rdc("modulo", tpwm_pkg::OFS_MOD, 32'h0000_0009);
		rdc("unmapped", 8'h80, 32'h0000_0000);
		// Buffered pair 4/5, both select bits set
		wr(8'h34, 32'h0000_0002);
		wr(8'h1C, 32'h0000_003A);
		wr(8'h00, 32'h0000_0000);
		repeat (40) @(posedge clk_i);
		meas(4, 72);
		chk("odd enable", 32'(ch_oe[5]), 32'h0000_0000);
		wr(8'h38, 32'h0000_0006); // Inactive register only
		repeat (40) @(posedge clk_i);
		meas(4, 168);
		wr(8'h20, 32'h0000_0020);
		rdc("odd status", 8'h20, 32'h0000_0000);
		rdc("even status", 8'h1C, 32'h0000_00BA);
		wait_m <= 1'b1;
		rdc("wait read", tpwm_pkg::OFS_MOD, 32'h0000_0000);
		wr(tpwm_pkg::OFS_MOD, 32'h0000_0003);
		meas(4, 168);
		wait_m <= 1'b0;
		rdc("modulo", tpwm_pkg::OFS_MOD, 32'h0000_0009);
		stop_m <= 1'b1;
		@(posedge clk_i);
		lv = ch_out[4];
		u_pin.measure(4, 240, h);
		chk("frozen", 32'(h), lv ? 32'h0000_00F0 : 32'h0000_0000);
		stop_m <= 1'b0;
		meas(4, 168);
		// Second reset in mid-run
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("outputs", 32'({ch_oe, ch_out, 5'h00, irq_o}), 32'h0000_0000);
		rdc("status", 8'h00, 32'h0000_0020);
		rdc("modulo", tpwm_pkg::OFS_MOD, 32'h0000_FFFF);
		rdc("counter", tpwm_pkg::OFS_CNT, 32'h0000_0000);
		summarize();
	end
endmodule
`default_nettype wire
